//--- src/gpio_port.sv
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "gpio_port_params.svh"
// Function
// - input pin: data read returns pin level
// - output pin: data read returns stored bit
// - data write stores all bits; outputs drive
// - reset clears data, pins float unless claimed by the peripheral, pullups off
// - direction zero: driver off, read pin
// - direction one: driver on, read stored
// - pullup bit turns pullup on or off
// - output pins never have pullup enabled
// - slew bit limits slew, outputs only
// - drive bit selects low or high drive
// - direction bit picks read source under override
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  // avalon-mm slave
  input  wire logic [`PORT_ADDR_W-1:0] avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [31:0]             avs_writedata_in,
  input  wire logic [3:0]              avs_byteenable_in,
  output logic      [31:0]             avs_readdata_out,
  output logic                         avs_waitrequest_out,
  output logic      [1:0]              avs_response_out,
  // peripheral override of direction and output data
  input  wire logic [WIDTH-1:0]        periph_own_in,
  input  wire logic [WIDTH-1:0]        periph_oe_in,
  input  wire logic [WIDTH-1:0]        periph_data_in,
  // pins
  input  wire logic [WIDTH-1:0]        pin_in,
  output logic      [WIDTH-1:0]        pin_out,
  output logic      [WIDTH-1:0]        pin_oe_out,
  output logic      [WIDTH-1:0]        pullup_en_out,
  output logic      [WIDTH-1:0]        slew_en_out,
  output logic      [WIDTH-1:0]        high_drive_out
);

  // ----------------------------------------------------------------------
  // register address decode
  // ----------------------------------------------------------------------
  function automatic reg_sel_t decode_sel(input logic [`PORT_ADDR_W-1:0] addr);
    unique case (addr)
      `PORT_ADDR_W'(`PORT_A_DATA_OFS):      decode_sel = SEL_DATA;
      `PORT_ADDR_W'(`PORT_A_DIRECTION_OFS): decode_sel = SEL_DIR;
      `PORT_ADDR_W'(`PORT_A_PULLUP_OFS):    decode_sel = SEL_PULL;
      `PORT_ADDR_W'(`PORT_A_SLEW_OFS):      decode_sel = SEL_SLEW;
      `PORT_A_DRIVE_OFS:                    decode_sel = SEL_DRIVE;
      default:                              decode_sel = SEL_NONE;
    endcase
  endfunction : decode_sel

  // ----------------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] pin_sync;

  pin_sync #(
    .WIDTH (WIDTH)
  ) pin_sync_inst (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ----------------------------------------------------------------------
  // registers and bus slave
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] data_reg;
  logic [WIDTH-1:0] data_next;
  logic [WIDTH-1:0] dir_reg;
  logic [WIDTH-1:0] dir_next;
  logic [WIDTH-1:0] pull_reg;
  logic [WIDTH-1:0] pull_next;
  logic [WIDTH-1:0] slew_reg;
  logic [WIDTH-1:0] slew_next;
  logic [WIDTH-1:0] drive_reg;
  logic [WIDTH-1:0] drive_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic [1:0]       resp_reg;
  logic [1:0]       resp_next;
  bus_state_t       bus_reg;
  bus_state_t       bus_next;
  reg_sel_t         sel;
  logic             lane0_we;
  logic [WIDTH-1:0] wbyte;
  logic [WIDTH-1:0] data_view;

  assign sel      = decode_sel(avs_address_in);
  assign lane0_we = avs_write_in && avs_byteenable_in[0] && (bus_reg == BUS_IDLE);
  assign wbyte    = avs_writedata_in[WIDTH-1:0];

  // read source chosen by the direction bit alone, even under override
  assign data_view = (dir_reg & data_reg) | (~dir_reg & pin_sync);

  // next-state: one access is answered in the cycle after it is seen;
  // a one-cycle wait keeps read data registered at no decode cost
  always_comb begin
    data_next  = data_reg;
    dir_next   = dir_reg;
    pull_next  = pull_reg;
    slew_next  = slew_reg;
    drive_next = drive_reg;
    rdata_next = rdata_reg;
    resp_next  = resp_reg;
    bus_next   = BUS_IDLE;
    if (bus_reg == BUS_IDLE && (avs_read_in || avs_write_in)) begin
      bus_next  = BUS_DONE;
      resp_next = (sel == SEL_NONE) ? `PORT_RESP_SLVERR : `PORT_RESP_OKAY;
      if (lane0_we) begin
        unique case (sel)
          SEL_DATA:  data_next  = wbyte;
          SEL_DIR:   dir_next   = wbyte;
          SEL_PULL:  pull_next  = wbyte;
          SEL_SLEW:  slew_next  = wbyte;
          SEL_DRIVE: drive_next = wbyte;
          default:   ;
        endcase
      end
      if (avs_read_in) begin
        unique case (sel)
          SEL_DATA:  rdata_next = 32'(data_view);
          SEL_DIR:   rdata_next = 32'(dir_reg);
          SEL_PULL:  rdata_next = 32'(pull_reg);
          SEL_SLEW:  rdata_next = 32'(slew_reg);
          SEL_DRIVE: rdata_next = 32'(drive_reg);
          default:   rdata_next = `PORT_UNMAPPED_DATA;
        endcase
      end
    end
  end

  // all port state clears on reset, pins not claimed by the peripheral come up as floating inputs
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_reg  <= `PORT_REG_RESET;
      dir_reg   <= `PORT_REG_RESET;
      pull_reg  <= `PORT_REG_RESET;
      slew_reg  <= `PORT_REG_RESET;
      drive_reg <= `PORT_REG_RESET;
      rdata_reg <= `PORT_UNMAPPED_DATA;
      resp_reg  <= `PORT_RESP_OKAY;
      bus_reg   <= BUS_IDLE;
    end else begin
      data_reg  <= data_next;
      dir_reg   <= dir_next;
      pull_reg  <= pull_next;
      slew_reg  <= slew_next;
      drive_reg <= drive_next;
      rdata_reg <= rdata_next;
      resp_reg  <= resp_next;
      bus_reg   <= bus_next;
    end
  end

  // waitrequest drops only in the answer cycle
  assign avs_waitrequest_out = (bus_reg == BUS_IDLE);
  assign avs_readdata_out    = rdata_reg;
  assign avs_response_out    = resp_reg;

  // ----------------------------------------------------------------------
  // pin control
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] oe_eff;
  logic [WIDTH-1:0] pad_data;

  // per pin: peripheral owns direction and data where it claims the pin
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      assign oe_eff[gi]   = periph_own_in[gi] ? periph_oe_in[gi] : dir_reg[gi];
      assign pad_data[gi] = periph_own_in[gi] ? periph_data_in[gi] : data_reg[gi];
    end
  endgenerate

  // pullup is cut whenever the pin drives, whoever owns it
  assign pin_out        = pad_data;
  assign pin_oe_out     = oe_eff;
  assign pullup_en_out  = pull_reg & ~oe_eff;
  assign slew_en_out    = slew_reg & oe_eff;
  assign high_drive_out = drive_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // a byte-lane write to the data register, taken by the idle slave
  sequence s_data_write;
    avs_write_in && avs_waitrequest_out && lane0_we && sel == SEL_DATA;
  endsequence

  // any access seen while the slave is idle
  sequence s_access_taken;
    (avs_read_in || avs_write_in) && bus_reg == BUS_IDLE;
  endsequence

  // exactly one answer cycle, then busy again
  sequence s_answer_cycle;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  // stored byte equals the written lane
  a_data_write_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_data_write |=> data_reg == $past(wbyte))
    else $error("data write not stored");

  // read source picked bit by bit
  a_read_source: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (avs_read_in && bus_reg == BUS_IDLE && sel == SEL_DATA)
      |=> avs_readdata_out[WIDTH-1:0] ==
          (($past(dir_reg) & $past(data_reg)) | (~$past(dir_reg) & $past(pin_sync))))
    else $error("data read source wrong");

  // all inputs: the read shows the synced pins
  a_input_read_pin: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (avs_read_in && bus_reg == BUS_IDLE && sel == SEL_DATA && dir_reg == '0)
      |=> avs_readdata_out[WIDTH-1:0] == $past(pin_sync))
    else $error("input read not pin level");

  // all outputs: the read shows the stored byte
  a_output_read_data: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (avs_read_in && bus_reg == BUS_IDLE && sel == SEL_DATA && dir_reg == '1)
      |=> avs_readdata_out[WIDTH-1:0] == $past(data_reg))
    else $error("output read not stored");

  // without override the port owns driver and data
  a_driver_enable: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (periph_own_in == '0) |-> pin_oe_out == dir_reg && pin_out == data_reg)
    else $error("driver not per direction");

  // with full override the peripheral owns driver and data
  a_override_pins: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (periph_own_in == '1) |-> pin_oe_out == periph_oe_in && pin_out == periph_data_in)
    else $error("override not applied");

  // no pullup while the pad drives
  a_pullup_cut: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (pullup_en_out & pin_oe_out) == '0)
    else $error("pullup on output pin");

  // port outputs cut the pullup whatever its bit says
  a_pullup_dir_cut: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (dir_reg == '1 && periph_own_in == '0) |-> pullup_en_out == '0)
    else $error("pullup on port output");

  // floating inputs follow their pullup bits
  a_pullup_follow: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (pin_oe_out == '0) |-> pullup_en_out == pull_reg)
    else $error("pullup not per bit");

  // pullup byte lands where it was written
  a_pull_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (lane0_we && sel == SEL_PULL) |=> pull_reg == $past(wbyte))
    else $error("pullup write not stored");

  // slew limiting is meaningless on an input
  a_slew_inputs: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (slew_en_out & ~pin_oe_out) == '0)
    else $error("slew on input pin");

  // driving pins follow their slew bits
  a_slew_follow: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (pin_oe_out == '1) |-> slew_en_out == slew_reg)
    else $error("slew not per bit");

  // slew byte lands where it was written
  a_slew_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (lane0_we && sel == SEL_SLEW) |=> slew_reg == $past(wbyte))
    else $error("slew write not stored");

  // drive select follows its write
  a_drive_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (lane0_we && sel == SEL_DRIVE) |=> high_drive_out == $past(wbyte))
    else $error("drive select not updated");

  // drive select is not gated by direction
  a_drive_follow: assert property (@(posedge clk_in) disable iff (!rstn_in)
    high_drive_out == drive_reg)
    else $error("drive select not per bit");

  // direction byte lands where it was written
  a_dir_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (lane0_we && sel == SEL_DIR) |=> dir_reg == $past(wbyte))
    else $error("direction write not stored");

  // data holds unless its own write is taken
  a_data_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(lane0_we && sel == SEL_DATA) |=> $stable(data_reg))
    else $error("data changed without write");

  // direction holds unless its own write is taken
  a_dir_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(lane0_we && sel == SEL_DIR) |=> $stable(dir_reg))
    else $error("direction changed without write");

  // a write without the low lane stores nothing
  a_lane_refused: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (avs_write_in && !avs_byteenable_in[0] && bus_reg == BUS_IDLE)
      |=> $stable(data_reg) && $stable(dir_reg) && $stable(pull_reg)
          && $stable(slew_reg) && $stable(drive_reg))
    else $error("refused write stored");

  // reads never disturb the port state
  a_read_no_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (avs_read_in && !avs_write_in)
      |=> $stable(data_reg) && $stable(dir_reg) && $stable(pull_reg)
          && $stable(slew_reg) && $stable(drive_reg))
    else $error("read changed a register");

  // unmapped address answers with an error code
  a_unmapped_resp: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_access_taken ##0 (sel == SEL_NONE) |=> avs_response_out == `PORT_RESP_SLVERR)
    else $error("unmapped access not refused");

  // mapped address answers okay
  a_mapped_resp: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_access_taken ##0 (sel != SEL_NONE) |=> avs_response_out == `PORT_RESP_OKAY)
    else $error("mapped access refused");

  // byte registers sit in the low lane only
  a_read_upper_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
    avs_readdata_out[31:WIDTH] == '0)
    else $error("upper read lanes not zero");

  // read data stand past the answer cycle
  a_read_stands: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !avs_waitrequest_out |=> $stable(avs_readdata_out) && $stable(avs_response_out))
    else $error("read data did not stand");

  // one wait cycle, one answer cycle
  a_bus_answer: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_access_taken |=> s_answer_cycle)
    else $error("bus answer timing wrong");

  // reset floats every pin not claimed by the peripheral, and every pullup is off
  a_reset_float: assert property (@(posedge clk_in)
    !rstn_in |-> pin_oe_out == '0 && pullup_en_out == '0)
    else $error("pins not floating in reset");

  // reset clears every port register
  a_reset_regs: assert property (@(posedge clk_in)
    !rstn_in |-> data_reg == '0 && dir_reg == '0 && pull_reg == '0
                 && slew_reg == '0 && drive_reg == '0)
    else $error("registers not cleared in reset");
endmodule : gpio_port

//--- src/gpio_port_params.svh
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

// ----------------------------------------------------------------------
// register map, byte addresses on a 32-bit avalon word bus
// ----------------------------------------------------------------------
`define PORT_A_DATA_OFS      5'h00
`define PORT_A_DIRECTION_OFS 5'h04
`define PORT_A_PULLUP_OFS    5'h08
`define PORT_A_SLEW_OFS      5'h0C
`define PORT_A_DRIVE_OFS     5'h10
`define PORT_ADDR_W          5
`define PORT_REG_RESET       8'h00
`define PORT_UNMAPPED_DATA   32'h0000_0000
`define PORT_RESP_OKAY       2'h0
`define PORT_RESP_SLVERR     2'h2

`endif

//--- src/gpio_port_pkg.sv
package gpio_port_pkg;
  // register selector decoded from the avalon address
  typedef enum logic [2:0] {
    SEL_DATA  = 3'b000,
    SEL_DIR   = 3'b001,
    SEL_PULL  = 3'b010,
    SEL_SLEW  = 3'b011,
    SEL_DRIVE = 3'b100,
    SEL_NONE  = 3'b111
  } reg_sel_t;

  // bus answer sequencing
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_t;
endpackage : gpio_port_pkg

//--- src/pin_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser, one per pin
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage is read only by the second
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : pin_sync

//--- verif/parallel_port_a_pin_control_tb.sv
`timescale 1ns/10ps
`include "gpio_port_params.svh"
module parallel_port_a_pin_control_tb;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [7:0]  own = 8'h00, poe = 8'h00, pdata = 8'h00, ext_en = 8'hFF, ext_val = 8'h00;
  logic [31:0] rdata;
  logic        wait_req;
  logic [1:0]  resp;
  logic [7:0]  lvl, drv, oe, pull, slew, drive;
  logic [33:0] exp_q[$];
  logic [7:0]  seed = 8'h06;
  logic [7:0]  dir, dat, pe, se, ds;
  int          miscompares = 0;
  int          comparisons = 0;

  initial forever #4 clk_in = ~clk_in;

  gpio_port #(.WIDTH(8)) gpio_port_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(address), .avs_read_in(read), .avs_write_in(write),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .avs_response_out(resp), .periph_own_in(own),
    .periph_oe_in(poe), .periph_data_in(pdata), .pin_in(lvl), .pin_out(drv),
    .pin_oe_out(oe), .pullup_en_out(pull), .slew_en_out(slew), .high_drive_out(drive));
  pin_model pin_model_inst (.clk_in(clk_in), .pin_drv_in(drv), .pin_oe_in(oe),
    .pullup_in(pull), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic next(output logic [7:0] v);
    seed = lfsr(seed);
    v = seed;
  endtask : next
  task automatic chk(input logic [33:0] exp, input logic [33:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    @(posedge clk_in);
    address <= a;
    write <= w;
    read <= ~w;
    wdata <= {24'h0, d};
    be <= b;
    do @(posedge clk_in); while (wait_req !== 1'b0);
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] b = 4'hF);
    bus(1'b1, a, d, b);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
    exp_q.push_back({r, 24'h0, d});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask : rd
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // read answers compared against the oldest note
  always @(posedge clk_in) begin
    if (read && wait_req === 1'b0) begin
      if (exp_q.size() == 0) chk(34'h0, 34'h3_FFFF_FFFF);
      else chk(exp_q.pop_front(), {resp, rdata});
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    chk(34'h0, 34'({oe, pull}));
    rstn_in <= 1'b1;
    for (int i = 0; i < 5; i++) rd(5'(4 * i), 8'h00);
    $display("test reset_values done");
    repeat (6) begin
      next(dir);
      next(dat);
      next(pe);
      next(se);
      next(ds);
      @(posedge clk_in);
      ext_val <= seed ^ 8'h3C;
      wr(`PORT_A_DATA_OFS, dat);
      wr(`PORT_A_DIRECTION_OFS, dir);
      wr(`PORT_A_PULLUP_OFS, pe);
      wr(`PORT_A_SLEW_OFS, se);
      wr(`PORT_A_DRIVE_OFS, ds);
      repeat (3) @(posedge clk_in);
      chk(34'(dir), 34'(oe));
      chk(34'(dat & dir), 34'(drv & dir));
      chk(34'(pe & ~dir), 34'(pull));
      chk(34'(se & dir), 34'(slew));
      chk(34'(ds), 34'(drive));
      rd(`PORT_A_DATA_OFS, (dir & dat) | (~dir & ext_val));
      rd(`PORT_A_DIRECTION_OFS, dir);
      rd(`PORT_A_PULLUP_OFS, pe);
      rd(`PORT_A_SLEW_OFS, se);
      rd(`PORT_A_DRIVE_OFS, ds);
    end
    $display("test random_config done");
    wr(`PORT_A_DIRECTION_OFS, 8'hFF);
    wr(`PORT_A_DATA_OFS, 8'hA5);
    wr(`PORT_A_DATA_OFS, 8'h5A, 4'hE);
    rd(`PORT_A_DATA_OFS, 8'hA5);
    rd(5'h14, 8'h00, 2'b10);
    $display("test refused_access done");
    wr(`PORT_A_PULLUP_OFS, 8'hFF);
    wr(`PORT_A_DIRECTION_OFS, 8'h00);
    @(posedge clk_in);
    own <= 8'hFF;
    poe <= 8'hFF;
    pdata <= 8'h3C;
    repeat (3) @(posedge clk_in);
    chk(34'h0, 34'(pull));
    rd(`PORT_A_DATA_OFS, 8'h3C);
    wr(`PORT_A_DIRECTION_OFS, 8'hFF);
    rd(`PORT_A_DATA_OFS, 8'hA5);
    own <= 8'h00;
    $display("test peripheral_override done");
    repeat (2) @(posedge clk_in);
    chk(34'h0, 34'(exp_q.size()));
    finish_test();
  end

  // cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    finish_test();
  end
endmodule : parallel_port_a_pin_control_tb

//--- verif/pin_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// circuitry outside the port pins
// ------------------------------------------------------------
module pin_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] pin_drv_in,
  input  wire logic [7:0] pin_oe_in,
  input  wire logic [7:0] pullup_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_val_in,
  output logic      [7:0] level_out
);
  logic [7:0] float_reg = 8'h5A;
  // an undriven pin without pullup toggles, so a stale value never passes
  always @(posedge clk_in) begin
    float_reg <= ~float_reg;
  end
  // port driver wins, then the outside source, then the pullup
  assign level_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext_en_in & ext_val_in)
                   | (~pin_oe_in & ~ext_en_in & (pullup_in | float_reg));
endmodule : pin_model
